// ===== hdl/dkf_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Error sense skips only with no late, parity or lock error
// - Late flag on unserviced or unaccepted break
// - Parity fault on bad read parity
// - Lower-half lockout write sets low error
// - Upper-half lockout write sets high error
// - Extender lock error shares status position
// - Address match flag held; sense skips
// - Status bit 11 shows gap mark
// - Status word field layout
// - Interrupt when transfer done sets
// - Missing unit: no transfer, flag, interrupt
// - Master plus up to three extenders
// - Write start loads address, requests break
// - Address increments until count overflow
// - 16 tracks, 2048 words, 13 bits
// - Address decoded serially over one word
// - Transfer at word after recognised address
// - Interleaved physical address order assumed
// - NRZI: toggle on ones only
// - 13th cell resets flux for parity
// - Read pulse is one, none zero
// - Read same as write, reversed direction
// - Completion sense skips when done
// - Clear resets address, flags, request
// - Write start clears accumulator, parity and done flags
// - Address wrap carries into track/unit
module dkf_ctrl (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire dkf_pkg::dkf_iot_s iot_i,
  input  wire logic [11:0]       ac_i,
  input  wire logic [2:0]        core_field_i,
  output logic                   skip_o,
  output logic                   ac_clear_o,
  output logic                   ac_load_o,
  output logic [11:0]            ac_data_o,
  output logic                   irq_o,
  output logic                   brk_req_o,
  output logic                   brk_write_o,
  output logic [11:0]            brk_data_o,
  input  wire logic              addr_accept_i,
  input  wire logic [11:0]       brk_data_i,
  input  wire logic              count_overflow_i,
  input  wire logic              clock_timing_track_i,
  input  wire logic              address_timing_track_i,
  input  wire logic              word_mark_i,
  input  wire logic              gap_mark_i,
  input  wire logic              read_flux_i,
  input  wire logic [3:0]        unit_present_i,
  input  wire logic [1:0]        master_unit_i,
  input  wire logic [3:0]        lock_low_i,
  input  wire logic [3:0]        lock_high_i,
  output logic                   flux_toggle_o,
  output logic                   write_en_o,
  output logic [3:0]             track_o,
  output logic [1:0]             unit_o
);
  dkf_pkg::dkf_state_e state_q, state_d;
  logic [11:0] dwa_q, dwa_d, buf_q, buf_d, ac_data_d;
  logic [4:0]  tus_q, tus_d;
  logic [12:0] rd_q, rd_d;
  logic [10:0] ashift_q;
  logic [3:0]  bit_q;
  logic [8:0]  adc_q;
  logic dir_q, dir_d, brk_q, brk_d, ovf_q, ovf_d, done_q, done_d, miss_q, miss_d;
  logic late_q, late_d, par_q, par_d, lol_q, lol_d, loh_q, loh_d, exp_q, exp_d;
  logic flux_q, flux_d, gap_q, skip_q, acc_q, acl_q, irq_q, wen_q, fin;

  // Instruction decode, one programmed I/O cycle per valid
  wire [2:0] p          = iot_i.pulse;
  wire       iot_mem    = iot_i.valid && iot_i.sel == dkf_pkg::SEL_MEM;
  wire       iot_ext    = iot_i.valid && iot_i.sel == dkf_pkg::SEL_EXT;
  wire       iot_flg    = iot_i.valid && iot_i.sel == dkf_pkg::SEL_FLAG;
  wire       do_clear   = iot_mem && p[0];
  wire       do_read    = iot_mem && p[1] && !p[2];
  wire       do_write   = iot_mem && p[2];
  wire       ext_clear  = iot_ext && p[0];
  wire       adc_sense  = iot_ext && p[1];
  wire       ext_load   = iot_ext && p[2];
  wire       err_sense  = iot_flg && p[0];
  wire       done_sense = iot_flg && p[1] && !p[2];
  wire       dwa_read   = iot_flg && p[2];

  // Status word and error summary
  wire        err_any  = late_q | par_q | lol_q | loh_q | exp_q;
  wire        adc_w    = adc_q != dkf_pkg::ADC_RST;
  wire [11:0] status_w = {gap_q, tus_q, core_field_i, late_q, miss_q | exp_q, par_q};
  // Disk address as one 17-bit count: unit, track, word
  wire [16:0] nxt_w    = {tus_q, dwa_q} + 17'h00001;
  wire [1:0]  unit_w   = tus_q[4:3];
  wire        unit_ok  = unit_present_i[unit_w];
  wire        nxt_ok   = unit_present_i[nxt_w[16:15]];
  wire        strobe   = clock_timing_track_i;
  wire        match_w  = word_mark_i && ashift_q == dwa_q[10:0];
  wire        lock_hit = tus_q[2] ? lock_high_i[unit_w] : lock_low_i[unit_w];
  wire        extender = unit_w != master_unit_i;
  wire        svc      = brk_q && addr_accept_i;
  wire [4:0]  tus_or   = adc_sense ? 5'h00 : ac_i[10:6];

  // Bit cell counter and serial address decode within each word period
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_q    <= 4'h0;
      ashift_q <= 11'h000;
    end else if (word_mark_i) begin
      bit_q    <= 4'h0;
    end else if (strobe && bit_q < dkf_pkg::CELL_BITS) begin
      bit_q    <= bit_q + 4'h1;
      if (bit_q < dkf_pkg::ADDR_BITS)
        ashift_q <= {ashift_q[9:0], address_timing_track_i};
    end
  end

  // Address confirmed hold, diagnostic only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      adc_q <= dkf_pkg::ADC_RST;
    else if (do_clear)
      adc_q <= dkf_pkg::ADC_RST;
    else if (match_w)
      adc_q <= 9'(dkf_pkg::ADC_CYCLES);
    else if (adc_w)
      adc_q <= adc_q - 9'h001;
  end

  // Transfer control; later statements take priority over earlier ones
  always_comb begin
    state_d = state_q;
    dwa_d = dwa_q;
    tus_d = tus_q;
    dir_d = dir_q;
    brk_d = brk_q;
    buf_d = buf_q;
    rd_d = rd_q;
    ovf_d = ovf_q;
    done_d = done_q;
    miss_d = miss_q;
    late_d = late_q;
    par_d = par_q;
    lol_d = lol_q;
    loh_d = loh_q;
    exp_d = exp_q;
    flux_d = flux_q;
    fin = 1'b0;
    // Break serviced: a write takes its word, overflow ends the block
    if (svc) begin
      brk_d = 1'b0;
      ovf_d = ovf_q | count_overflow_i;
      if (dir_q)
        buf_d = brk_data_i;
      else if (count_overflow_i)
        fin = 1'b1;
    end
    case (state_q)
      dkf_pkg::ST_SEARCH: begin
        if (match_w && dir_q && lock_hit) begin
          lol_d = lol_q | !tus_q[2];
          loh_d = loh_q | tus_q[2];
          exp_d = exp_q | extender;
          fin = 1'b1;
        end else if (match_w) begin
          state_d = dkf_pkg::ST_XFER;
          if (dir_q && brk_q)
            late_d = 1'b1;
        end
      end
      dkf_pkg::ST_XFER: begin
        if (strobe && dir_q && bit_q < dkf_pkg::DATA_BITS) begin
          flux_d = flux_q ^ buf_q[11];
          buf_d = {buf_q[10:0], 1'b0};
        end
        if (strobe && dir_q && bit_q == dkf_pkg::DATA_BITS)
          flux_d = 1'b0;
        if (strobe && !dir_q && bit_q < dkf_pkg::CELL_BITS)
          rd_d = {rd_q[11:0], read_flux_i};
        // Word end: step the address, then feed or drain the break channel
        if (word_mark_i) begin
          {tus_d, dwa_d} = nxt_w;
          state_d = dkf_pkg::ST_SEARCH;
          if (brk_q)
            late_d = 1'b1;
          if (!dir_q) begin
            buf_d = rd_q[12:1];
            par_d = par_q | (^rd_q);
            brk_d = 1'b1;
          end else if (ovf_q) begin
            fin = 1'b1;
          end else begin
            brk_d = 1'b1;
          end
          if (!nxt_ok && !fin) begin
            miss_d = 1'b1;
            state_d = dkf_pkg::ST_IDLE;
          end
        end
      end
      default: ;
    endcase
    if (fin) begin
      done_d = 1'b1;
      state_d = dkf_pkg::ST_IDLE;
    end
    // Clear instruction; lock flags also drop so software can retry
    if (do_clear) begin
      dwa_d = dkf_pkg::DWA_RST;
      par_d = 1'b0;
      done_d = 1'b0;
      miss_d = 1'b0;
      late_d = 1'b0;
      lol_d = 1'b0;
      loh_d = 1'b0;
      exp_d = 1'b0;
      brk_d = 1'b0;
      state_d = dkf_pkg::ST_IDLE;
    end
    // Read or write start; an absent unit gets no transfer
    if (do_read || do_write) begin
      dwa_d = ac_i;
      dir_d = do_write;
      par_d = 1'b0;
      done_d = 1'b0;
      ovf_d = 1'b0;
      flux_d = 1'b0;
      if (!unit_ok) begin
        miss_d = 1'b1;
        state_d = dkf_pkg::ST_IDLE;
      end else begin
        brk_d = do_write;
        state_d = dkf_pkg::ST_SEARCH;
      end
    end
    // Track and unit select: clear, then or in the accumulator
    if (ext_clear)
      tus_d = dkf_pkg::TUS_RST;
    if (ext_load)
      tus_d = tus_d | tus_or;
  end

  // Answers to the processor, one cycle after the instruction
  wire skip_d = (err_sense && !err_any) || (done_sense && done_q)
                || (adc_sense && adc_w);
  wire acl_d  = do_read || do_write || adc_sense || (iot_flg && p[1] && p[2]);
  assign ac_data_d = ext_load ? status_w : (dwa_read ? dwa_q : 12'h000);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      skip_q <= 1'b0;
      acl_q <= 1'b0;
      acc_q <= 1'b0;
      ac_data_o <= 12'h000;
      gap_q <= 1'b0;
      irq_q <= 1'b0;
      wen_q <= 1'b0;
    end else begin
      skip_q <= skip_d;
      acl_q <= acl_d;
      acc_q <= ext_load || dwa_read;
      ac_data_o <= ac_data_d;
      gap_q <= gap_mark_i;
      irq_q <= done_d || miss_d;
      wen_q <= state_d == dkf_pkg::ST_XFER && dir_d;
    end
  end

  // Control state registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= dkf_pkg::ST_IDLE;
      dwa_q <= dkf_pkg::DWA_RST;
      tus_q <= dkf_pkg::TUS_RST;
      buf_q <= 12'h000;
      rd_q <= 13'h0000;
      {dir_q, brk_q, ovf_q, done_q, miss_q, late_q} <= 6'h00;
      {par_q, lol_q, loh_q, exp_q, flux_q} <= 5'h00;
    end else begin
      state_q <= state_d;
      dwa_q <= dwa_d;
      tus_q <= tus_d;
      buf_q <= buf_d;
      rd_q <= word_mark_i ? 13'h0000 : rd_d;
      {dir_q, brk_q, ovf_q, done_q, miss_q, late_q} <= {dir_d, brk_d, ovf_d, done_d, miss_d, late_d};
      {par_q, lol_q, loh_q, exp_q, flux_q} <= {par_d, lol_d, loh_d, exp_d, flux_d};
    end
  end

  assign skip_o = skip_q;
  assign ac_clear_o = acl_q;
  assign ac_load_o = acc_q;
  assign irq_o = irq_q;
  assign brk_req_o = brk_q;
  assign brk_write_o = dir_q;
  assign brk_data_o = buf_q;
  assign flux_toggle_o = flux_q;
  assign write_en_o = wen_q;
  assign track_o = {tus_q[2:0], dwa_q[11]};
  assign unit_o = tus_q[4:3];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_err_skip: assert property (err_sense && !p[1] |=> skip_o == !$past(err_any))
    else $error("error sense skip wrong");
  a_done_skip: assert property (done_sense |=> skip_o == $past(done_q))
    else $error("completion sense skip wrong");
  a_adc_hold: assert property (disable iff (!rst_n_i || do_clear) match_w |=> adc_w [*8])
    else $error("address match flag not held");
  a_parity_chk: assert property (state_q == dkf_pkg::ST_XFER && word_mark_i && !dir_q
    && (^rd_q) |=> par_q)
    else $error("parity fault not raised");
  a_flux_park: assert property (state_q == dkf_pkg::ST_XFER && dir_q && strobe
    && bit_q == dkf_pkg::DATA_BITS && !word_mark_i && !iot_i.valid |=> !flux_toggle_o)
    else $error("parity cell did not reset flux");
  a_flux_zero: assert property (state_q == dkf_pkg::ST_XFER && dir_q && strobe
    && !buf_q[11] && bit_q < dkf_pkg::DATA_BITS && !iot_i.valid |=> $stable(flux_toggle_o))
    else $error("flux moved on a zero bit");
  a_start_brk: assert property (do_write && !do_clear && unit_ok |=> brk_req_o ##0
    dwa_q == $past(ac_i))
    else $error("write start did not request break");
  a_missing: assert property ((do_read || do_write) && !unit_ok |=> miss_q
    && state_q == dkf_pkg::ST_IDLE ##1 irq_o)
    else $error("missing unit not flagged");
  a_status_map: assert property (ext_load |=> ac_load_o && ac_data_o[dkf_pkg::ST_LATE]
    == $past(late_q) && ac_data_o[dkf_pkg::ST_PAR] == $past(par_q))
    else $error("status word layout wrong");
  a_late_flag: assert property (state_q == dkf_pkg::ST_XFER && word_mark_i && brk_q
    && !iot_i.valid |=> late_q)
    else $error("late request not flagged");
endmodule

// ===== hdl/dkf_pkg.sv
package dkf_pkg;
  // Clock rate and the address-confirmed hold time, least time rounded up
  localparam int CLK_MHZ     = 25;
  localparam int ADC_HOLD_NS = 16000;
  localparam int ADC_CYCLES  = (ADC_HOLD_NS * CLK_MHZ + 999) / 1000;
  // Word geometry: 12 data bits, 13 bit cells, 11-bit track word address
  localparam logic [3:0] DATA_BITS = 4'hc;
  localparam logic [3:0] CELL_BITS = 4'hd;
  localparam logic [3:0] ADDR_BITS = 4'hb;
  // Programmed I/O sub-device selects
  localparam logic [1:0] SEL_MEM  = 2'h0;
  localparam logic [1:0] SEL_EXT  = 2'h1;
  localparam logic [1:0] SEL_FLAG = 2'h2;
  // Status word field positions (bit 11 is the leftmost accumulator bit)
  localparam int ST_GAP  = 11;
  localparam int ST_TUS  = 6;
  localparam int ST_CF   = 3;
  localparam int ST_LATE = 2;
  localparam int ST_UNIT = 1;
  localparam int ST_PAR  = 0;
  // Values after reset
  localparam logic [11:0] DWA_RST = 12'h000;
  localparam logic [4:0]  TUS_RST = 5'h00;
  localparam logic [8:0]  ADC_RST = 9'h000;

  typedef enum logic [1:0] {ST_IDLE, ST_SEARCH, ST_XFER} dkf_state_e;

  // One programmed I/O cycle: valid, sub-device, pulse bits 1/2/4
  typedef struct packed {
    logic       valid;
    logic [1:0] sel;
    logic [2:0] pulse;
  } dkf_iot_s;
endpackage

// ===== dv/dkf_brk_model.sv
`timescale 1ns/1ps
// Processor data-break side: answers each request after a settable wait
module dkf_brk_model (
  input  wire logic        clk_i,
  input  wire logic        brk_req_i,
  input  wire logic        brk_write_i,
  input  wire logic [11:0] brk_word_i,
  input  wire logic        stall_i,
  input  wire logic [1:0]  delay_i,
  output logic             addr_accept_o,
  output logic [11:0]      brk_word_o,
  output logic             count_overflow_o
);
  logic [11:0] mem [16];
  logic [11:0] wc_q   = 12'h000;
  logic [11:0] ca_q   = 12'h000;
  logic [1:0]  wait_q = 2'h0;

  // Defined levels before the first edge
  initial begin
    addr_accept_o = 1'b0;
    brk_word_o = 12'h000;
    count_overflow_o = 1'b0;
  end

  // Count holds the negated total, pointer starts one below the block
  task automatic setup(input logic [11:0] words, input logic [11:0] first);
    wc_q = -words;
    ca_q = first - 12'h001;
  endtask

  // Released lines flip each cycle so a stale word is never mistaken for data
  always @(posedge clk_i) begin
    addr_accept_o <= 1'b0;
    brk_word_o <= ~brk_word_o;
    count_overflow_o <= ~count_overflow_o;
    if (!brk_req_i || addr_accept_o || stall_i) begin
      wait_q <= delay_i;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else begin
      addr_accept_o <= 1'b1;
      wc_q = wc_q + 12'h001;
      ca_q = ca_q + 12'h001;
      brk_word_o <= mem[ca_q[3:0]];
      count_overflow_o <= (wc_q == 12'h000);
      if (!brk_write_i) begin
        mem[ca_q[3:0]] = brk_word_i;
      end
    end
  end
endmodule

// ===== dv/test_dkf_ctrl.sv
`timescale 1ns/1ps
module test_dkf_ctrl;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  dkf_pkg::dkf_iot_s iot = '0;
  logic [11:0]       ac = 12'h000;
  logic              wm = 1'b0, ctt = 1'b0, att = 1'b0, rf = 1'b0, gap = 1'b0;
  logic [3:0]        lock_hi = 4'h0, lock_lo = 4'h0, trk;
  logic              stall = 1'b0;
  logic [1:0]        dly = 2'h3, unt;
  logic              skip, clr, ld, irq, breq, bwr, flux, wen, acc, ovf, sk, cl, lo;
  logic [11:0]       dat, bdo, bdi, ad;
  logic [10:0]       bad_pa = 11'h7ff;
  logic [12:0]       wq[$];
  logic [10:0]       wa[$];
  int                mismatches = 0;
  int                comparisons = 0;

  dkf_ctrl i_dkf_ctrl (.clk_i(clk), .rst_n_i(rst_n), .iot_i(iot), .ac_i(ac),
    .core_field_i(3'h5), .skip_o(skip), .ac_clear_o(clr), .ac_load_o(ld), .ac_data_o(dat),
    .irq_o(irq), .brk_req_o(breq), .brk_write_o(bwr), .brk_data_o(bdo),
    .addr_accept_i(acc), .brk_data_i(bdi), .count_overflow_i(ovf),
    .clock_timing_track_i(ctt), .address_timing_track_i(att), .word_mark_i(wm),
    .gap_mark_i(gap), .read_flux_i(rf), .unit_present_i(4'h5), .master_unit_i(2'h0),
    .lock_low_i(lock_lo), .lock_high_i(lock_hi), .flux_toggle_o(flux), .write_en_o(wen),
    .track_o(trk), .unit_o(unt));

  dkf_brk_model i_dkf_brk_model (.clk_i(clk), .brk_req_i(breq), .brk_write_i(bwr),
    .brk_word_i(bdo), .stall_i(stall), .delay_i(dly), .addr_accept_o(acc),
    .brk_word_o(bdi), .count_overflow_o(ovf));

  // 25 MHz clock
  initial forever #20 clk = ~clk;

  // Disk word: data MSB first then even parity; one address may carry bad parity
  function automatic logic [12:0] rd_pat(input logic [10:0] a);
    logic [11:0] d;
    d = {1'b0, a} ^ 12'h9c3;
    return {d, (^d) ^ (a == bad_pa)};
  endfunction

  // Flux level after each cell when writing d from reset state
  function automatic logic [12:0] wexp(input logic [11:0] d);
    logic f;
    f = 1'b0;
    for (int k = 0; k < 12; k++) begin
      f = f ^ d[11 - k];
      wexp[12 - k] = f;
    end
    wexp[0] = 1'b0;
  endfunction

  // Disk timing: a short revolution of 8 interleaved slots keeps searches brief
  initial begin : disk
    logic [10:0] pa;
    logic [12:0] rp, fs;
    logic        we;
    pa = 11'h000;
    wait (rst_n);
    forever begin
      rp = rd_pat(pa);
      @(posedge clk) wm <= 1'b1;
      @(posedge clk) wm <= 1'b0;
      for (int k = 0; k < 13; k++) begin
        @(posedge clk) ctt <= 1'b1;
        att <= (k < 11) ? pa[10 - k] : 1'b0;
        rf <= rp[12 - k];
        @(posedge clk) ctt <= 1'b0;
        #1 fs[12 - k] = flux;
        if (k == 0) we = wen;
      end
      if (we) wq.push_back(fs);
      if (we) wa.push_back(pa);
      pa = (pa[10:9] == 2'h3) ? {10'h000, ~pa[0]} : pa + 11'h200;
    end
  end

  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // One I/O instruction; answers are captured in the cycle they stand
  task automatic io(input logic [1:0] s, input logic [2:0] p, input logic [11:0] a);
    @(posedge clk);
    iot <= '{1'b1, s, p};
    ac <= a;
    @(posedge clk);
    iot <= '0;
    #1;
    sk = skip;
    cl = clr;
    lo = ld;
    ad = dat;
  endtask

  task automatic xfer(input logic [2:0] p, input logic [11:0] n, input logic [11:0] st);
    wq.delete();
    wa.delete();
    i_dkf_brk_model.setup(n, st);
    io(2'h0, p, 12'h000);
    chk("ac clear", 1'b1, cl);
    chk("start request", p[2], breq);
    chk("direction", p[2], bwr);
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge clk);
    #1 chk("done irq", 1'b1, irq);
  endtask

  task automatic t_status();
    @(posedge clk) gap <= 1'b1;
    io(2'h1, 3'h5, 12'h500);
    chk("unit select", 2'h2, unt);
    chk("track select", 4'h8, trk);
    io(2'h1, 3'h4, 12'h000);
    chk("status load", 1'b1, lo);
    chk("status word", 12'hd28, ad);
    io(2'h2, 3'h1, 12'h000);
    chk("error sense", 1'b1, sk);
    chk("idle data", 12'h000, ad);
    io(2'h2, 3'h2, 12'h000);
    chk("done sense", 1'b0, sk);
    @(posedge clk) gap <= 1'b0;
  endtask

  // Extender unit 2, upper half locked
  task automatic t_lock();
    @(posedge clk) lock_hi <= 4'h4;
    xfer(3'h5, 12'h001, 12'h001);
    io(2'h1, 3'h2, 12'h000);
    chk("match sense", 1'b1, sk);
    io(2'h1, 3'h4, 12'h000);
    chk("lock status", 12'h52a, ad);
    io(2'h2, 3'h1, 12'h000);
    chk("lock sense", 1'b0, sk);
    io(2'h0, 3'h1, 12'h000);
    chk("irq cleared", 1'b0, irq);
    io(2'h1, 3'h5, 12'h000);
    @(posedge clk) lock_hi <= 4'h0;
    lock_lo <= 4'h1;
    // Master unit 0, lower half locked: no expander bit in status
    xfer(3'h5, 12'h001, 12'h001);
    io(2'h2, 3'h1, 12'h000);
    chk("low lock sense", 1'b0, sk);
    io(2'h1, 3'h4, 12'h000);
    chk("master lock status", 12'h028, ad);
    io(2'h0, 3'h1, 12'h000);
    @(posedge clk) lock_lo <= 4'h0;
  endtask

  task automatic t_write();
    i_dkf_brk_model.mem[1] = 12'h5a3;
    i_dkf_brk_model.mem[2] = 12'h0ff;
    xfer(3'h5, 12'h002, 12'h001);
    chk("words written", 13'h2, wq.size());
    chk("first slot", 11'h200, wa[0]);
    chk("second slot", 11'h201, wa[1]);
    chk("first flux", wexp(12'h5a3), wq[0]);
    chk("second flux", wexp(12'h0ff), wq[1]);
    io(2'h2, 3'h2, 12'h000);
    chk("done sense", 1'b1, sk);
  endtask

  // Prompt channel; second word carries bad parity
  task automatic t_read();
    bad_pa = 11'h201;
    @(posedge clk) dly <= 2'h0;
    xfer(3'h3, 12'h002, 12'h008);
    io(2'h2, 3'h4, 12'h000);
    chk("final address", 12'h002, ad);
    chk("first read", rd_pat(11'h200) >> 1, i_dkf_brk_model.mem[8]);
    chk("second read", rd_pat(11'h201) >> 1, i_dkf_brk_model.mem[9]);
    io(2'h1, 3'h4, 12'h000);
    chk("parity status", 1'b1, ad[0]);
    io(2'h2, 3'h1, 12'h000);
    chk("parity sense", 1'b0, sk);
    io(2'h0, 3'h1, 12'h000);
    io(2'h1, 3'h4, 12'h000);
    chk("parity cleared", 1'b0, ad[0]);
    @(posedge clk) dly <= 2'h3;
  endtask

  // Channel never answers the opening request
  task automatic t_late();
    @(posedge clk) stall <= 1'b1;
    io(2'h0, 3'h5, 12'h000);
    for (int i = 0; i < 400 && ad[2] !== 1'b1; i++) io(2'h1, 3'h4, 12'h000);
    chk("late status", 1'b1, ad[2]);
    io(2'h0, 3'h1, 12'h000);
    chk("request dropped", 1'b0, breq);
    @(posedge clk) stall <= 1'b0;
  endtask

  // Unit 3 is not attached
  task automatic t_missing();
    io(2'h1, 3'h5, 12'h600);
    wq.delete();
    io(2'h0, 3'h5, 12'h000);
    for (int i = 0; i < 600 && irq !== 1'b1; i++) @(posedge clk);
    #1 chk("missing irq", 1'b1, irq);
    io(2'h1, 3'h4, 12'h000);
    chk("missing status", 1'b1, ad[1]);
    chk("no transfer", 13'h0, wq.size());
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog: all transfers fit well inside this span
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_status();
    t_lock();
    t_write();
    t_read();
    t_late();
    t_missing();
    print_verdict();
  end
endmodule
